// file: rtl/jmc_top.v
// command-driven serial test-port master channel
//
// Notes on behaviour
// (RQ1) receive buffer holds captured bits after scan
// (RQ2) transmit and receive buffers share storage flops
// (RQ3) controller reads results before rewriting buffer
// (RQ4) auto start command begins the scan
// (RQ5) auto scan running: requests get busy error
// (RQ6) auto scan acknowledged only after completion
// (RQ7) manual start acknowledges first, keeps serving
// (RQ8) control bit 8 busy during manual scan
// (RQ9) controller avoids writes while busy flag set
// (RQ10) reset command pulses slave reset, length-scaled
// (RQ11) replies echo channel and transaction, carry error
// (RQ12) control and divider 16-bit write and read
// (RQ13) serial-out buffer written as four words
// (RQ14) receive buffer read as four words
// (RQ15) mode-select buffer written and read as words
// (RQ16) length field, zero means full 128 bits
// (RQ17) test clock from divider value
// (RQ18) sample edge, launch edge, order, idle level
// (RQ19) one bit per clock period, stop idle
`include "jmc_defines.vh"

module jmc_top #(
  parameter BUF_BITS = 128,
  parameter FIFO_DEPTH = 32,
  parameter FIFO_AW = 5
) (
  input wire clk,
  input wire sys_rst,
  input wire req_valid,
  output wire req_ready,
  input wire [7:0] req_chan,
  input wire [7:0] req_trn,
  input wire [7:0] req_cmd,
  input wire [31:0] req_data,
  output reg rep_valid_ff,
  input wire rep_ready,
  output reg [7:0] rep_chan_ff,
  output reg [7:0] rep_trn_ff,
  output reg [7:0] rep_len_ff,
  output reg [7:0] rep_err_ff,
  output reg [31:0] rep_data_ff,
  output reg tck_ff,
  output reg tms_ff,
  output reg tdo_ff,
  input wire tdi,
  output reg slave_reset_out_ff,
  output reg busy_ff
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_SCAN = 1'b1;

  // word index of a buffer command: upper nibble low two bits
  function [1:0] word_sel;
    input [7:0] cmd;
    begin
      word_sel = cmd[5:4];
    end
  endfunction

  // true for a buffer access of the given sub-code, serial-out or mode-select
  function is_buf_cmd;
    input [7:0] cmd;
    input [3:0] sub;
    begin
      is_buf_cmd = (cmd[7] == 1'b0) && (cmd[3:0] == sub);
    end
  endfunction

  // ----------------------------------------------------------------
  // request fifo
  // ----------------------------------------------------------------
  wire f_valid;
  wire f_ready;
  wire [55:0] f_data;

  jmc_fifo #(
    .WIDTH(56),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data({req_chan, req_trn, req_cmd, req_data}),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  wire [7:0] c_chan = f_data[55:48];
  wire [7:0] c_trn = f_data[47:40];
  wire [7:0] c_cmd = f_data[39:32];
  wire [31:0] c_data = f_data[31:0];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [15:0] ctrl_ff;
  reg [15:0] div_ff;
  reg [BUF_BITS-1:0] data_buf_ff;
  reg [BUF_BITS-1:0] tms_buf_ff;
  reg st_ff;
  reg auto_ff;
  reg ack_pend_ff;
  reg [7:0] go_trn_ff;
  reg [6:0] pos_ff;
  reg [7:0] left_ff;
  reg sampled_ff;
  reg phase_ff;
  reg [15:0] half_cnt_ff;
  reg [7:0] srst_cnt_ff;

  wire [6:0] scan_length = ctrl_ff[`JMC_CTRL_LEN_HI:0];
  // a zero length field stands for the full buffer
  wire [7:0] nbits = (scan_length == 7'h00) ? `JMC_FULL_LEN : {1'b0, scan_length}; // RQ16
  wire sample_edge_sel = ctrl_ff[`JMC_CTRL_SMP_EDGE];
  wire launch_edge_sel = ctrl_ff[`JMC_CTRL_LNCH_EDGE];
  wire lsb_first = ctrl_ff[`JMC_CTRL_LSBF];
  wire clock_idle_invert = ctrl_ff[`JMC_CTRL_IDLE_INV];
  wire idle_lvl = ~clock_idle_invert; // RQ18

  // half period rounds up; at this system clock the fastest rate is a quarter of nominal
  wire [31:0] half_w = ({16'h0000, div_ff} + 32'd1 + `JMC_HALF_DEN - 32'd1) / `JMC_HALF_DEN; // RQ17
  wire [15:0] half_cyc = (half_w[15:0] == 16'h0000) ? 16'h0001 : half_w[15:0];
  wire [31:0] srst_w = ({25'd0, scan_length} * `JMC_SRST_UNIT_NS + `JMC_CLK_PERIOD_NS - 32'd1)
                       / `JMC_CLK_PERIOD_NS; // RQ10
  wire [7:0] srst_cyc = (srst_w[7:0] == 8'h00) ? 8'h01 : srst_w[7:0];

  wire [6:0] start_pos = lsb_first ? 7'h00 : nbits[6:0] - 7'h01; // RQ18
  wire [6:0] step_pos = lsb_first ? pos_ff + 7'h01 : pos_ff - 7'h01;

  // ----------------------------------------------------------------
  // clock edge classification during a scan
  // ----------------------------------------------------------------
  wire tog = (st_ff == ST_SCAN) && (half_cnt_ff == 16'h0000);
  wire nt = ~tck_ff;
  wire is_sample = tog && (nt ^ sample_edge_sel); // RQ18
  wire is_launch = tog && (nt ^ launch_edge_sel); // RQ18
  wire do_sample = is_sample && !sampled_ff;
  wire [7:0] left_after = do_sample ? left_ff - 8'h01 : left_ff;
  wire do_launch = is_launch && (sampled_ff || is_sample) && (left_after != 8'h00);
  wire scan_done = tog && phase_ff && (left_after == 8'h00); // RQ19

  // one command per free reply slot; the delayed auto acknowledge goes first
  wire take = f_valid && !rep_valid_ff && !ack_pend_ff;
  assign f_ready = take;

  // ----------------------------------------------------------------
  // scan engine, buffers and command execution
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      ctrl_ff <= `JMC_CTRL_RST;
      div_ff <= `JMC_DIV_RST;
      data_buf_ff <= {BUF_BITS{1'b0}};
      tms_buf_ff <= {BUF_BITS{1'b0}};
      st_ff <= ST_IDLE;
      auto_ff <= 1'b0;
      ack_pend_ff <= 1'b0;
      go_trn_ff <= 8'h00;
      pos_ff <= 7'h00;
      left_ff <= 8'h00;
      sampled_ff <= 1'b0;
      phase_ff <= 1'b0;
      half_cnt_ff <= 16'h0000;
      srst_cnt_ff <= 8'h00;
      busy_ff <= 1'b0;
      tck_ff <= 1'b1;
      tms_ff <= 1'b0;
      tdo_ff <= 1'b0;
      slave_reset_out_ff <= 1'b0;
      rep_valid_ff <= 1'b0;
      rep_chan_ff <= 8'h00;
      rep_trn_ff <= 8'h00;
      rep_len_ff <= 8'h00;
      rep_err_ff <= 8'h00;
      rep_data_ff <= 32'h00000000;
    end else begin
      // ---- reply slot
      if (rep_valid_ff && rep_ready) begin
        rep_valid_ff <= 1'b0;
      end
      if (ack_pend_ff && !rep_valid_ff) begin
        rep_valid_ff <= 1'b1; // RQ6
        rep_chan_ff <= `JMC_CHAN;
        rep_trn_ff <= go_trn_ff;
        rep_len_ff <= `JMC_LEN_SHORT;
        rep_err_ff <= `JMC_ERR_NONE;
        rep_data_ff <= 32'h00000000;
        ack_pend_ff <= 1'b0;
      end

      // ---- slave reset pulse
      if (srst_cnt_ff != 8'h00) begin
        srst_cnt_ff <= srst_cnt_ff - 8'h01;
        slave_reset_out_ff <= (srst_cnt_ff != 8'h01);
      end

      // ---- scan clocking
      if (st_ff == ST_IDLE) begin
        tck_ff <= idle_lvl; // RQ18
      end else if (tog) begin
        tck_ff <= nt;
        phase_ff <= ~phase_ff;
        half_cnt_ff <= half_cyc - 16'h0001; // RQ17
        if (do_sample) begin
          data_buf_ff[pos_ff] <= tdi; // RQ2
          sampled_ff <= 1'b1;
          left_ff <= left_after;
        end
        if (do_launch) begin
          pos_ff <= step_pos; // RQ19
          tdo_ff <= data_buf_ff[step_pos];
          tms_ff <= tms_buf_ff[step_pos];
          sampled_ff <= 1'b0;
        end
        if (scan_done) begin
          st_ff <= ST_IDLE; // RQ1
          busy_ff <= 1'b0; // RQ8
          auto_ff <= 1'b0;
          if (auto_ff) begin
            ack_pend_ff <= 1'b1; // RQ6
          end
        end
      end else begin
        half_cnt_ff <= half_cnt_ff - 16'h0001;
      end

      // ---- command execution
      if (take) begin
        rep_valid_ff <= 1'b1;
        rep_chan_ff <= c_chan; // RQ11
        rep_trn_ff <= c_trn; // RQ11
        rep_len_ff <= `JMC_LEN_SHORT;
        rep_err_ff <= `JMC_ERR_NONE;
        rep_data_ff <= 32'h00000000;
        if (c_chan != `JMC_CHAN) begin
          rep_err_ff <= `JMC_ERR_CHAN;
        end else if ((st_ff == ST_SCAN) && auto_ff) begin
          rep_err_ff <= `JMC_ERR_BUSY; // RQ5
        end else if (c_cmd == `JMC_CMD_W_CTRL) begin
          ctrl_ff <= {c_data[15:9], 1'b0, c_data[7:0]}; // RQ12
        end else if (c_cmd == `JMC_CMD_R_CTRL) begin
          rep_len_ff <= `JMC_LEN_DATA;
          rep_data_ff <= {16'h0000, ctrl_ff[15:9], busy_ff, ctrl_ff[7:0]}; // RQ8
        end else if (c_cmd == `JMC_CMD_W_DIV) begin
          div_ff <= c_data[15:0]; // RQ12
        end else if (c_cmd == `JMC_CMD_R_DIV) begin
          rep_len_ff <= `JMC_LEN_DATA;
          rep_data_ff <= {16'h0000, div_ff}; // RQ12
        end else if ((c_cmd == `JMC_CMD_GO_AUTO) || (c_cmd == `JMC_CMD_GO_MAN)) begin
          if (st_ff == ST_SCAN) begin
            rep_err_ff <= `JMC_ERR_BUSY;
          end else begin
            st_ff <= ST_SCAN; // RQ4
            busy_ff <= 1'b1; // RQ8
            pos_ff <= start_pos;
            left_ff <= nbits;
            sampled_ff <= 1'b0;
            phase_ff <= 1'b0;
            half_cnt_ff <= half_cyc - 16'h0001;
            tck_ff <= idle_lvl;
            tdo_ff <= data_buf_ff[start_pos];
            tms_ff <= tms_buf_ff[start_pos];
            if (c_cmd == `JMC_CMD_GO_AUTO) begin
              // acknowledge withheld until the scan ends
              auto_ff <= 1'b1; // RQ6
              go_trn_ff <= c_trn;
              rep_valid_ff <= 1'b0;
            end else begin
              auto_ff <= 1'b0; // RQ7
            end
          end
        end else if (c_cmd == `JMC_CMD_SLV_RST) begin
          srst_cnt_ff <= srst_cyc; // RQ10
          slave_reset_out_ff <= 1'b1;
        end else if (is_buf_cmd(c_cmd, `JMC_SUB_WRITE)) begin
          // a serial-out write lands on captured bits; results must be read first
          if (c_cmd[6]) begin
            tms_buf_ff[{word_sel(c_cmd), 5'b00000} +: 32] <= c_data; // RQ15
          end else begin
            data_buf_ff[{word_sel(c_cmd), 5'b00000} +: 32] <= c_data; // RQ13
          end
        end else if (is_buf_cmd(c_cmd, `JMC_SUB_READ)) begin
          rep_len_ff <= `JMC_LEN_DATA;
          if (c_cmd[6]) begin
            rep_data_ff <= tms_buf_ff[{word_sel(c_cmd), 5'b00000} +: 32]; // RQ15
          end else begin
            rep_data_ff <= data_buf_ff[{word_sel(c_cmd), 5'b00000} +: 32]; // RQ14
          end
        end else begin
          rep_err_ff <= `JMC_ERR_CMD;
        end
      end
    end
  end

endmodule // jmc_top

// file: rtl/jmc_defines.vh
// constants shared by the scan channel files
`ifndef JMC_DEFINES_VH
`define JMC_DEFINES_VH

// ----------------------------------------------------------------
// channel, commands and reply codes
// ----------------------------------------------------------------
`define JMC_CHAN 8'h13
`define JMC_CMD_W_CTRL 8'h80
`define JMC_CMD_R_CTRL 8'h81
`define JMC_CMD_W_DIV 8'h90
`define JMC_CMD_R_DIV 8'h91
`define JMC_CMD_GO_AUTO 8'ha2
`define JMC_CMD_GO_MAN 8'hb0
`define JMC_CMD_SLV_RST 8'hc0
`define JMC_SUB_WRITE 4'h0
`define JMC_SUB_READ 4'h1
`define JMC_ERR_NONE 8'h00
`define JMC_ERR_BUSY 8'h04
`define JMC_ERR_CHAN 8'h08
`define JMC_ERR_CMD 8'h10
`define JMC_LEN_SHORT 8'h02
`define JMC_LEN_DATA 8'h06

// ----------------------------------------------------------------
// control field layout and reset values
// ----------------------------------------------------------------
`define JMC_CTRL_LEN_HI 6
`define JMC_CTRL_BUSY 8
`define JMC_CTRL_SMP_EDGE 9
`define JMC_CTRL_LNCH_EDGE 10
`define JMC_CTRL_LSBF 11
`define JMC_CTRL_IDLE_INV 14
`define JMC_CTRL_RST 16'h1000
`define JMC_DIV_RST 16'h0000
`define JMC_FULL_LEN 8'h80

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define JMC_CLK_HZ 32'd10000000
`define JMC_CLK_PERIOD_NS 32'd100
`define JMC_TCK_BASE_HZ 32'd20000000
`define JMC_HALF_DEN ((32'd2 * `JMC_TCK_BASE_HZ) / `JMC_CLK_HZ)
`define JMC_SRST_UNIT_NS 32'd25

`endif

// file: rtl/jmc_fifo.v
// request fifo with registered read data and registered flags
module jmc_fifo #(
  parameter WIDTH = 56,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire clk,
  input wire sys_rst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0] cnt_ff;
  reg full_ff;
  reg [WIDTH-1:0] dout_ff;
  reg dvalid_ff;

  wire push = in_valid && !full_ff;
  // the output register refills whenever it empties or is being drained
  wire pop = (cnt_ff != {(AW+1){1'b0}}) && (!dvalid_ff || out_ready);
  wire [AW:0] nxt_cnt = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  assign in_ready = !full_ff;
  assign out_valid = dvalid_ff;
  assign out_data = dout_ff;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
      full_ff <= 1'b0;
      dout_ff <= {WIDTH{1'b0}};
      dvalid_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      full_ff <= (nxt_cnt == DEPTH[AW:0]);
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        dout_ff <= mem[rd_ptr_ff];
        rd_ptr_ff <= rd_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
        dvalid_ff <= 1'b1;
      end else if (out_ready) begin
        dvalid_ff <= 1'b0;
      end
    end
  end

endmodule // jmc_fifo

// file: bench/jmc_slave_model.sv
// behavioural scan slave facing the channel pins
module jmc_slave_model (
  input wire tck,
  input wire tdo,
  input wire tms,
  output wire tdi,
  output reg [15:0] pulses,
  output reg [127:0] tms_seen
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pulses = 16'h0000;
  // inverted echo: every captured bit must differ from the bit sent
  assign tdi = ~tdo;
  always @(posedge tck) pulses <= pulses + 16'h0001;
  // mode-select taken on the falling clock, clear of the rising launch edge but not of the falling launch edge that t_man uses
  always @(negedge tck) tms_seen <= {tms_seen[126:0], tms};
endmodule // jmc_slave_model

// file: bench/jmc_top_asserts.sv
// concurrent checks on the scan channel top ports
module jmc_top_asserts (
  input wire clk,
  input wire sys_rst,
  input wire req_ready,
  input wire rep_valid_ff,
  input wire rep_ready,
  input wire [7:0] rep_chan_ff,
  input wire [7:0] rep_trn_ff,
  input wire [7:0] rep_len_ff,
  input wire [7:0] rep_err_ff,
  input wire [31:0] rep_data_ff,
  input wire tck_ff,
  input wire tms_ff,
  input wire tdo_ff,
  input wire slave_reset_out_ff,
  input wire busy_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  reg [7:0] rst_w_ff;
  always @(posedge clk) rst_w_ff <= (sys_rst || !slave_reset_out_ff) ? 8'h00 : rst_w_ff + 8'h01;
  a_reply_holds: assert property (rep_valid_ff && !rep_ready |=> rep_valid_ff &&
    $stable(rep_data_ff) && $stable(rep_trn_ff) && $stable(rep_err_ff))
    else $error("reply dropped or changed before taken");
  a_reply_chan: assert property (rep_valid_ff && rep_err_ff != 8'h08 |-> rep_chan_ff == 8'h13)
    else $error("reply channel wrong");
  a_reply_len: assert property (rep_valid_ff |-> rep_len_ff == 8'h02 || rep_len_ff == 8'h06)
    else $error("reply length illegal");
  a_short_nodata: assert property (rep_valid_ff && rep_len_ff == 8'h02 |-> rep_data_ff == 32'h0)
    else $error("short reply carries data");
  a_reset_outs: assert property (disable iff (1'b0) sys_rst |=> !rep_valid_ff && tck_ff &&
    !busy_ff && !slave_reset_out_ff) else $error("outputs wrong after reset");
  a_ready_release: assert property ($fell(sys_rst) |-> ##1 req_ready)
    else $error("request port not ready after reset");
  a_pulse_width: assert property (rst_w_ff <= 8'd32)
    else $error("slave reset pulse too long");
  a_pins_quiet: assert property (!busy_ff && !$past(busy_ff) |-> $stable(tdo_ff) && $stable(tms_ff))
    else $error("scan pins moved while idle");
endmodule // jmc_top_asserts
bind jmc_top jmc_top_asserts u_chk (.clk(clk), .sys_rst(sys_rst), .req_ready(req_ready),
  .rep_valid_ff(rep_valid_ff), .rep_ready(rep_ready), .rep_chan_ff(rep_chan_ff),
  .rep_trn_ff(rep_trn_ff), .rep_len_ff(rep_len_ff), .rep_err_ff(rep_err_ff),
  .rep_data_ff(rep_data_ff), .tck_ff(tck_ff), .tms_ff(tms_ff), .tdo_ff(tdo_ff),
  .slave_reset_out_ff(slave_reset_out_ff), .busy_ff(busy_ff));

// file: bench/jmc_top_tb_top.sv
// self-checking bench for the scan channel top
module jmc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  reg clk = 1'b0;
  reg sys_rst = 1'b1;
  reg req_valid = 1'b0;
  reg rep_ready = 1'b0;
  reg [7:0] req_chan = 8'h00;
  reg [7:0] req_trn = 8'h00;
  reg [7:0] req_cmd = 8'h00;
  reg [31:0] req_data = 32'h0;
  reg [7:0] trn = 8'h00;
  wire req_ready, rep_valid_ff, tck_ff, tms_ff, tdo_ff, tdi, slave_reset_out_ff, busy_ff;
  wire [7:0] rep_chan_ff, rep_trn_ff, rep_len_ff, rep_err_ff;
  wire [31:0] rep_data_ff;
  wire [15:0] pulses;
  wire [127:0] tms_seen;
  integer n_errors = 0;
  integer samples_checked = 0;
  integer rst_w = 0;
  integer i, n, b0;
  always #50 clk = ~clk;
  always @(posedge clk) if (slave_reset_out_ff) rst_w <= rst_w + 1;
  jmc_top uut (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid), .req_ready(req_ready),
    .req_chan(req_chan), .req_trn(req_trn), .req_cmd(req_cmd), .req_data(req_data),
    .rep_valid_ff(rep_valid_ff), .rep_ready(rep_ready), .rep_chan_ff(rep_chan_ff),
    .rep_trn_ff(rep_trn_ff), .rep_len_ff(rep_len_ff), .rep_err_ff(rep_err_ff),
    .rep_data_ff(rep_data_ff), .tck_ff(tck_ff), .tms_ff(tms_ff), .tdo_ff(tdo_ff), .tdi(tdi),
    .slave_reset_out_ff(slave_reset_out_ff), .busy_ff(busy_ff));
  jmc_slave_model u_slave (.tck(tck_ff), .tdo(tdo_ff), .tms(tms_ff), .tdi(tdi), .pulses(pulses),
    .tms_seen(tms_seen));
  // ----
  // transfer tasks
  // ----
  task chk(input string what, input [31:0] exp, input [31:0] got);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED %0s expected %h seen %h", what, exp, got);
    end
  endtask
  task snd(input [7:0] ch, input [7:0] c, input [31:0] d);
    integer k;
    @(negedge clk);
    req_valid = 1'b1;
    req_chan = ch;
    req_trn = trn;
    req_cmd = c;
    req_data = d;
    for (k = 0; k < 50 && req_ready !== 1'b1; k = k + 1) @(negedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    trn = trn + 8'h01;
  endtask
  task wrep;
    integer k;
    for (k = 0; k < 3000 && rep_valid_ff !== 1'b1; k = k + 1) @(negedge clk);
  endtask
  task ack;
    rep_ready = 1'b1;
    @(negedge clk);
    rep_ready = 1'b0;
  endtask
  task rcv(input [7:0] t, input [7:0] e, input [31:0] d);
    wrep;
    chk("trn", t, rep_trn_ff);
    chk("err", e, rep_err_ff);
    chk("data", d, rep_data_ff);
    ack;
  endtask
  task op(input [7:0] c, input [31:0] d, input [7:0] e, input [31:0] x);
    snd(8'h13, c, d);
    rcv(trn - 8'h01, e, x);
  endtask
  // ----
  // scenarios
  // ----
  task t_regs;
    integer k;
    op(8'h81, 0, 8'h00, 32'h1000);
    op(8'h90, 32'h00ff, 8'h00, 0);
    op(8'h91, 0, 8'h00, 32'h00ff);
    op(8'h80, 32'h0108, 8'h00, 0);
    op(8'h81, 0, 8'h00, 32'h0008);
    for (k = 0; k < 4; k = k + 1) begin
      op({k[1:0], 4'h0}, 32'hc3a50000 + k, 8'h00, 0);
      op({k[1:0], 4'h1}, 0, 8'h00, 32'hc3a50000 + k);
      op({2'b01, k[1:0], 4'h0}, 32'h5a3c0000 + k, 8'h00, 0);
      op({2'b01, k[1:0], 4'h1}, 0, 8'h00, 32'h5a3c0000 + k);
    end
    op(8'h55, 0, 8'h10, 0);
    snd(8'h12, 8'h81, 0);
    rcv(trn - 8'h01, 8'h08, 0);
    $display("t_regs done");
  endtask
  task t_auto;
    reg [7:0] g;
    b0 = pulses;
    op(8'h00, 32'h123456a5, 8'h00, 0);
    op(8'h40, 32'h5a3c00c6, 8'h00, 0);
    g = trn;
    snd(8'h13, 8'ha2, 0);
    repeat (20) @(negedge clk);
    snd(8'h13, 8'h81, 0);
    repeat (2) begin
      wrep;
      if (rep_trn_ff === g) begin
        chk("go err", 0, rep_err_ff);
        chk("busy at ack", 0, busy_ff);
      end else chk("busy err", 8'h04, rep_err_ff);
      ack;
    end
    chk("bits", b0 + 8, pulses);
    chk("tms bits", 8'hc6, tms_seen[7:0]);
    chk("tck idle", 1, tck_ff);
    op(8'h01, 0, 8'h00, 32'h1234565a);
    op(8'h11, 0, 8'h00, 32'hc3a50001);
    $display("t_auto done");
  endtask
  task t_man;
    integer k;
    reg bsy;
    op(8'h90, 0, 8'h00, 0);
    op(8'h80, 32'h4800, 8'h00, 0);
    chk("tck low", 0, tck_ff);
    for (k = 0; k < 4; k = k + 1) op({k[1:0], 4'h0}, 32'h0f0f0000 + k, 8'h00, 0);
    b0 = pulses;
    op(8'hb0, 0, 8'h00, 0);
    op(8'h81, 0, 8'h00, 32'h4900);
    bsy = 1'b1;
    // poll only: no writes while the scan runs
    for (k = 0; k < 100 && bsy; k = k + 1) begin
      snd(8'h13, 8'h81, 0);
      wrep;
      bsy = rep_data_ff[8];
      ack;
    end
    chk("busy end", 0, bsy);
    chk("bits", b0 + 128, pulses);
    chk("tck low", 0, tck_ff);
    for (k = 0; k < 4; k = k + 1) op({k[1:0], 4'h1}, 0, 8'h00, ~(32'h0f0f0000 + k));
    // falling-edge sample and launch, msb first, eight bits
    op(8'h80, 32'h0608, 8'h00, 0);
    op(8'h00, 32'h000000a5, 8'h00, 0);
    op(8'hb0, 0, 8'h00, 0);
    repeat (100) @(negedge clk);
    chk("tck high", 1, tck_ff);
    op(8'h01, 0, 8'h00, 32'h0000005a);
    $display("t_man done");
  endtask
  task t_rst;
    integer k;
    for (k = 0; k < 2; k = k + 1) begin
      op(8'h80, k ? 32'h007f : 32'h0008, 8'h00, 0);
      rst_w = 0;
      op(8'hc0, 0, 8'h00, 0);
      repeat (40) @(negedge clk);
      chk("pulse", k ? 32 : 2, rst_w);
    end
    $display("t_rst done");
  endtask
  task t_fifo;
    reg [7:0] t0;
    t0 = trn;
    n = 0;
    // replies stall, so the queue must fill and refuse
    while (req_ready === 1'b1 && n < 40) begin
      snd(8'h13, 8'h81, 0);
      n = n + 1;
    end
    if (n < 32) chk("fill", 32, n);
    chk("refused", 0, req_ready);
    for (i = 0; i < n; i = i + 1) rcv(t0 + i[7:0], 8'h00, 32'h007f);
    $display("t_fifo done");
  endtask
  task end_sim;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #2000000;
    n_errors = n_errors + 1;
    end_sim;
  end
  initial begin
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    t_regs;
    t_auto;
    t_man;
    t_rst;
    t_fifo;
    end_sim;
  end
endmodule // jmc_top_tb_top
